// File: trs_pkg.sv
package trs_pkg;
  // Frame geometry and limits
  localparam int NUM_TS = 2;
  localparam int NUM_KEYS = 16;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_OBJ = NUM_TS + 1;
  localparam int KEY_OBJ_IDX = NUM_TS;
  localparam int MAX_TOUCH = 10;
  localparam int CNT_W = 5;
  localparam int COORD_W = 12;
  localparam int SIG_W = 8;
  localparam int AREA_W = 8;
  // Reset values
  localparam logic [CNT_W-1:0] MAX_TOUCH_RST = 5'h0a;
  localparam logic [COORD_W-1:0] BORDER_RST = 12'h000;
  localparam logic [SIG_W-1:0] GLOVE_STRICT_RST = 8'h40;
  localparam logic [SIG_W-1:0] GLOVE_RELAX_RST = 8'h20;

  typedef enum logic [1:0] {
    TRS_TYPE_FINGER,
    TRS_TYPE_GLOVE,
    TRS_TYPE_STYLUS,
    TRS_TYPE_LARGE
  } trs_type_t;

  typedef enum {
    TRS_GLOVE_NORMAL,
    TRS_GLOVE_CONFIDENT
  } trs_glove_t;
endpackage : trs_pkg

// File: trs_suppress.sv
`timescale 1ns/1ps
`default_nettype none
//==================================================
// Overview of operation
// - Touch in group suppresses higher-index group objects
// - Object may belong to several groups
// - Internal suppression keeps only one key
// - Internal suppression only for key array
// - Too many touches suppress whole frame
// - Large area touches are suppressed
// - Touches in edge border suppressed
// - Normal glove mode uses strict threshold
// - Gloved touch enters glove confidence mode
// - Confidence mode uses relaxed glove threshold
// - Stylus uses its own thresholds
// - Fingers on a screen with an active stylus are suppressed
// - One stylus setting set per touchscreen
module trs_suppress
  import trs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic frame_i,
  input wire logic [NUM_TS*MAX_TOUCH-1:0] ts_touch_i,
  input wire logic [NUM_TS*MAX_TOUCH*COORD_W-1:0] ts_x_i,
  input wire logic [NUM_TS*MAX_TOUCH*COORD_W-1:0] ts_y_i,
  input wire logic [NUM_TS*MAX_TOUCH*SIG_W-1:0] ts_signal_i,
  input wire logic [NUM_TS*MAX_TOUCH*AREA_W-1:0] ts_area_i,
  input wire logic [NUM_TS*MAX_TOUCH-1:0] ts_stylus_i,
  input wire logic [NUM_KEYS-1:0] key_touch_i,
  input wire logic [NUM_KEYS*SIG_W-1:0] key_signal_i,
  input wire logic [NUM_OBJ*NUM_GROUPS-1:0] group_member_i,
  input wire logic key_internal_en_i,
  input wire logic max_touch_en_i,
  input wire logic [CNT_W-1:0] max_touch_i,
  input wire logic [COORD_W-1:0] x_max_i,
  input wire logic [COORD_W-1:0] y_max_i,
  input wire logic grip_en_i,
  input wire logic [COORD_W-1:0] border_i,
  input wire logic large_en_i,
  input wire logic [AREA_W-1:0] large_area_i,
  input wire logic [SIG_W-1:0] finger_thr_i,
  input wire logic [SIG_W-1:0] key_thr_i,
  input wire logic [NUM_TS*SIG_W-1:0] stylus_thr_i,
  input wire logic [NUM_TS*AREA_W-1:0] stylus_area_i,
  input wire logic [NUM_TS-1:0] stylus_supp_en_i,
  input wire logic glove_en_i,
  input wire logic [SIG_W-1:0] glove_strict_i,
  input wire logic [SIG_W-1:0] glove_relax_i,
  input wire logic glove_exit_i,
  output logic [NUM_TS*MAX_TOUCH-1:0] ts_report_o,
  output logic [NUM_KEYS-1:0] key_report_o,
  output logic glove_confident_o,
  output logic max_suppressed_o,
  output logic report_valid_o
);
  //==================================================
  // Reset release and frame strobe synchroniser
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [2:0] frame_sync_r;
  logic frame_go;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_sync_r <= 3'h0;
    end else begin
      frame_sync_r <= {frame_sync_r[1:0], frame_i};
    end
  end
  assign frame_go = frame_sync_r[1] && !frame_sync_r[2];

  //==================================================
  // Per-touch classification
  trs_glove_t glove_r;
  logic [SIG_W-1:0] glove_thr;
  logic [NUM_TS*MAX_TOUCH-1:0] t_valid;
  logic [NUM_TS*MAX_TOUCH-1:0] t_glove;
  logic [NUM_TS*MAX_TOUCH-1:0] t_stylus;
  logic [NUM_TS*MAX_TOUCH-1:0] t_finger;
  assign glove_thr = !glove_en_i ? {SIG_W{1'b1}} :
    (glove_r == TRS_GLOVE_CONFIDENT) ? glove_relax_i : glove_strict_i;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TS*MAX_TOUCH; gi++) begin : g_touch
      localparam int TS = gi / MAX_TOUCH;
      trs_touch_filter u_filter (
        .touch_i(ts_touch_i[gi]),
        .x_i(ts_x_i[gi*COORD_W +: COORD_W]),
        .y_i(ts_y_i[gi*COORD_W +: COORD_W]),
        .x_max_i(x_max_i),
        .y_max_i(y_max_i),
        .signal_i(ts_signal_i[gi*SIG_W +: SIG_W]),
        .area_i(ts_area_i[gi*AREA_W +: AREA_W]),
        .stylus_i(ts_stylus_i[gi]),
        .grip_en_i(grip_en_i),
        .border_i(border_i),
        .large_en_i(large_en_i),
        .large_area_i(large_area_i),
        .finger_thr_i(finger_thr_i),
        .stylus_thr_i(stylus_thr_i[TS*SIG_W +: SIG_W]),
        .stylus_area_i(stylus_area_i[TS*AREA_W +: AREA_W]),
        .glove_thr_i(glove_thr),
        .valid_o(t_valid[gi]),
        .glove_o(t_glove[gi]),
        .stylus_o(t_stylus[gi]),
        .near_stylus_o(t_finger[gi])
      );
    end
  endgenerate

  // Stylus hand rejection per touchscreen
  logic [NUM_TS*MAX_TOUCH-1:0] t_keep;
  generate
    for (gi = 0; gi < NUM_TS*MAX_TOUCH; gi++) begin : g_pen
      localparam int TS = gi / MAX_TOUCH;
      assign t_keep[gi] = t_valid[gi] && !(stylus_supp_en_i[TS] && t_finger[gi]
        && |t_stylus[TS*MAX_TOUCH +: MAX_TOUCH]);
    end
  endgenerate

  // Key array internal suppression: lowest touched key survives
  logic [NUM_KEYS-1:0] k_valid;
  logic [NUM_KEYS-1:0] k_keep;
  generate
    for (gi = 0; gi < NUM_KEYS; gi++) begin : g_key
      assign k_valid[gi] = key_touch_i[gi] && key_signal_i[gi*SIG_W +: SIG_W] >= key_thr_i;
    end
  endgenerate
  assign k_keep = key_internal_en_i ? (k_valid & (~k_valid + 16'h0001)) : k_valid;

  //==================================================
  // Group suppression between objects
  logic [NUM_OBJ-1:0] obj_act;
  logic [NUM_OBJ-1:0] obj_ok;
  generate
    for (gi = 0; gi < NUM_TS; gi++) begin : g_obj
      assign obj_act[gi] = |t_keep[gi*MAX_TOUCH +: MAX_TOUCH];
    end
  endgenerate
  assign obj_act[KEY_OBJ_IDX] = |k_keep;

  always_comb begin
    obj_ok = obj_act;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      for (int o = 0; o < NUM_OBJ; o++) begin
        for (int w = 0; w < o; w++) begin
          if (group_member_i[o*NUM_GROUPS+g] && group_member_i[w*NUM_GROUPS+g]
              && obj_act[w]) begin
            obj_ok[o] = 1'b0;
          end
        end
      end
    end
  end

  // Touch count for maximum touch suppression
  // One spare bit: screens and keys together exceed the limit's range
  logic [CNT_W:0] count;
  logic over_max;
  always_comb begin
    count = '0;
    for (int i = 0; i < NUM_TS*MAX_TOUCH; i++) begin
      count = count + (CNT_W+1)'(ts_touch_i[i]);
    end
    for (int i = 0; i < NUM_KEYS; i++) begin
      count = count + (CNT_W+1)'(key_touch_i[i]);
    end
  end
  assign over_max = max_touch_en_i && (count > {1'b0, max_touch_i});

  logic [NUM_TS*MAX_TOUCH-1:0] ts_final;
  generate
    for (gi = 0; gi < NUM_TS*MAX_TOUCH; gi++) begin : g_fin
      assign ts_final[gi] = t_keep[gi] && obj_ok[gi / MAX_TOUCH] && !over_max;
    end
  endgenerate

  //==================================================
  // Report registers, updated once per frame
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ts_report_o <= '0;
      key_report_o <= '0;
      max_suppressed_o <= 1'b0;
    end else if (frame_go) begin
      ts_report_o <= ts_final;
      key_report_o <= (obj_ok[KEY_OBJ_IDX] && !over_max) ? k_keep : '0;
      max_suppressed_o <= over_max;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      report_valid_o <= 1'b0;
    end else begin
      report_valid_o <= frame_go;
    end
  end

  // Glove classifier mode
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      glove_r <= TRS_GLOVE_NORMAL;
    end else if (!glove_en_i || glove_exit_i) begin
      glove_r <= TRS_GLOVE_NORMAL;
    end else if (frame_go && |(t_glove & ts_final)) begin
      glove_r <= TRS_GLOVE_CONFIDENT;
    end
  end
  assign glove_confident_o = (glove_r == TRS_GLOVE_CONFIDENT);

  //==================================================
  // Checks
  max_supp_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    frame_go && over_max |=> ts_report_o == '0 && key_report_o == '0 && max_suppressed_o)
    else $error("touches reported above maximum count");
  key_one_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    frame_go && key_internal_en_i |=> $onehot0(key_report_o))
    else $error("several keys reported with internal suppression");
  grp_win_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    frame_go && obj_act[0] && group_member_i[0] && group_member_i[KEY_OBJ_IDX*NUM_GROUPS]
    |=> key_report_o == '0)
    else $error("key reported while grouped screen touched");
  grp_prio_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    frame_go && !over_max && obj_act[0] |=> (ts_report_o[MAX_TOUCH-1:0] != '0))
    else $error("highest priority object lost");
  glove_ent_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    frame_go && glove_en_i && !glove_exit_i && |(t_glove & ts_final) |=> glove_confident_o)
    else $error("glove confidence not entered");
  glove_off_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !glove_en_i |=> !glove_confident_o)
    else $error("glove mode active while disabled");
  rpt_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    report_valid_o |=> !report_valid_o)
    else $error("report strobe longer than one cycle");
  hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !frame_go |=> $stable(ts_report_o))
    else $error("report changed outside frame");
endmodule // trs_suppress
`default_nettype wire

// File: trs_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin failures++; $display("MISMATCH %0t %s", $time, m); end end
module testbench;
  import trs_pkg::*;
  localparam int NT = NUM_TS * MAX_TOUCH;
  logic clk = 1'b0, rst_n = 1'b0, frame = 1'b0;
  logic [NT-1:0] ts_touch, ts_sty, ts_rep;
  logic [NT*COORD_W-1:0] ts_x, ts_y;
  logic [NT*SIG_W-1:0] ts_sig;
  logic [NT*AREA_W-1:0] ts_area;
  logic [NUM_KEYS-1:0] key_touch, key_rep;
  logic [NUM_KEYS*SIG_W-1:0] key_sig;
  logic [NUM_OBJ*NUM_GROUPS-1:0] grp = '0;
  logic key_int_en = 1'b0, max_en = 1'b0, grip_en = 1'b0, large_en = 1'b0;
  logic glove_en = 1'b0, glove_exit = 1'b0;
  logic [CNT_W-1:0] max_cnt = 5'h03;
  logic [COORD_W-1:0] border = 12'h010;
  logic [AREA_W-1:0] large_area = 8'h80;
  logic [NUM_TS*SIG_W-1:0] sty_thr = {8'h30, 8'h10};
  logic [NUM_TS*AREA_W-1:0] sty_area = {8'h04, 8'h04};
  logic [NUM_TS-1:0] sty_supp = '0;
  logic [SIG_W-1:0] glove_relax = GLOVE_RELAX_RST;
  logic glove_conf, max_supp, rep_valid;
  int failures = 0, check_count = 0;

  always #12.5 clk = ~clk;

  trs_suppress u_trs_suppress (.clk_i(clk), .reset_n_i(rst_n), .frame_i(frame),
    .ts_touch_i(ts_touch), .ts_x_i(ts_x), .ts_y_i(ts_y), .ts_signal_i(ts_sig),
    .ts_area_i(ts_area), .ts_stylus_i(ts_sty), .key_touch_i(key_touch),
    .key_signal_i(key_sig), .group_member_i(grp), .key_internal_en_i(key_int_en),
    .max_touch_en_i(max_en), .max_touch_i(max_cnt), .x_max_i(12'h100), .y_max_i(12'h100),
    .grip_en_i(grip_en), .border_i(border), .large_en_i(large_en),
    .large_area_i(large_area), .finger_thr_i(8'h50), .key_thr_i(8'h30),
    .stylus_thr_i(sty_thr), .stylus_area_i(sty_area), .stylus_supp_en_i(sty_supp),
    .glove_en_i(glove_en), .glove_strict_i(GLOVE_STRICT_RST), .glove_relax_i(glove_relax),
    .glove_exit_i(glove_exit), .ts_report_o(ts_rep), .key_report_o(key_rep),
    .glove_confident_o(glove_conf), .max_suppressed_o(max_supp), .report_valid_o(rep_valid));

  task automatic end_sim;
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Idle frame content: no touches, centred strong small contacts
  task automatic clr;
    ts_touch = '0;
    ts_sty = '0;
    key_touch = '0;
    ts_x = {NT{12'h080}};
    ts_y = {NT{12'h080}};
    ts_sig = {NT{8'hc0}};
    ts_area = {NT{8'h10}};
    key_sig = {NUM_KEYS{8'hc0}};
  endtask

  task automatic tch(input int s, input int i, input logic [11:0] x, input logic [7:0] sg,
                     input logic [7:0] ar, input int st);
    int k;
    k = s * MAX_TOUCH + i;
    ts_touch[k] = 1'b1;
    ts_x[k*COORD_W +: COORD_W] = x;
    ts_sig[k*SIG_W +: SIG_W] = sg;
    ts_area[k*AREA_W +: AREA_W] = ar;
    ts_sty[k] = (st != 0);
  endtask

  // Strobe one frame and wait for the report pulse
  task automatic frm;
    int n;
    @(posedge clk);
    #2 frame = 1'b1;
    @(posedge clk);
    #2 frame = 1'b0;
    for (n = 0; n < 10 && rep_valid !== 1'b1; n++) begin
      @(posedge clk);
      #2;
    end
    `CHK(rep_valid, 1'b1, "no report pulse")
    @(posedge clk);
    #2;
    `CHK(rep_valid, 1'b0, "report pulse too long")
  endtask

  task automatic chk(input logic [NT-1:0] et, input logic [NUM_KEYS-1:0] ek);
    `CHK(ts_rep, et, "screen report")
    `CHK(key_rep, ek, "key report")
  endtask

  initial begin
    #200000;
    failures++;
    end_sim;
  end

  initial begin
    clr;
    repeat (4) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk('0, '0);
    `CHK({glove_conf, max_supp, rep_valid}, 3'b000, "outputs after reset")
    grp = 12'h101;
    tch(0, 0, 12'h080, 8'hc0, 8'h10, 0);
    key_touch = 16'h0008;
    frm; chk(20'h00001, 16'h0000);
    clr; key_touch = 16'h0008;
    frm; chk(20'h00000, 16'h0008);
    grp = 12'h321;
    tch(1, 0, 12'h080, 8'hc0, 8'h10, 0);
    frm; chk(20'h00400, 16'h0000);
    grp = '0; clr; key_int_en = 1'b1;
    key_touch = 16'h0024;
    tch(0, 0, 12'h080, 8'hc0, 8'h10, 0);
    tch(0, 1, 12'h080, 8'hc0, 8'h10, 0);
    frm; chk(20'h00003, 16'h0004);
    key_int_en = 1'b0; key_touch = '0; max_en = 1'b1;
    tch(1, 0, 12'h080, 8'hc0, 8'h10, 0);
    frm; chk(20'h00403, 16'h0000);
    `CHK(max_supp, 1'b0, "count at limit")
    key_touch = 16'h0001;
    frm; chk(20'h00000, 16'h0000);
    `CHK(max_supp, 1'b1, "count over limit")
    max_cnt = 5'h1f;
    ts_touch = '1;
    key_touch = '1;
    frm; chk('0, '0);
    `CHK(max_supp, 1'b1, "count beyond counter range")
    max_en = 1'b0; clr; large_en = 1'b1;
    tch(0, 0, 12'h080, 8'hc0, 8'h90, 0);
    tch(0, 1, 12'h080, 8'hc0, 8'h80, 0);
    frm; chk(20'h00002, 16'h0000);
    large_en = 1'b0; clr; grip_en = 1'b1;
    tch(0, 0, 12'h005, 8'hc0, 8'h10, 0);
    tch(0, 1, 12'h080, 8'hc0, 8'h10, 0);
    frm; chk(20'h00002, 16'h0000);
    grip_en = 1'b0; clr; glove_en = 1'b1;
    tch(0, 0, 12'h080, 8'h30, 8'h10, 0);
    frm; chk(20'h00000, 16'h0000);
    `CHK(glove_conf, 1'b0, "glove mode stays normal")
    tch(0, 0, 12'h080, 8'h48, 8'h10, 0);
    frm; chk(20'h00001, 16'h0000);
    `CHK(glove_conf, 1'b1, "glove confidence entry")
    tch(0, 0, 12'h080, 8'h30, 8'h10, 0);
    frm; chk(20'h00001, 16'h0000);
    glove_relax = 8'h38;
    frm; chk(20'h00000, 16'h0000);
    glove_exit = 1'b1;
    frm;
    `CHK(glove_conf, 1'b0, "glove exit")
    glove_exit = 1'b0; glove_en = 1'b0; clr; sty_supp = 2'b01;
    tch(0, 0, 12'h080, 8'h20, 8'h02, 1);
    tch(1, 0, 12'h080, 8'h20, 8'h02, 1);
    tch(0, 1, 12'h080, 8'hc0, 8'h10, 0);
    tch(1, 1, 12'h080, 8'hc0, 8'h10, 0);
    frm; chk(20'h00801, 16'h0000);
    end_sim;
  end
endmodule // testbench
`default_nettype wire

// File: trs_touch_filter.sv
`timescale 1ns/1ps
`default_nettype none
module trs_touch_filter
  import trs_pkg::*;
(
  input wire logic touch_i,
  input wire logic [COORD_W-1:0] x_i,
  input wire logic [COORD_W-1:0] y_i,
  input wire logic [COORD_W-1:0] x_max_i,
  input wire logic [COORD_W-1:0] y_max_i,
  input wire logic [SIG_W-1:0] signal_i,
  input wire logic [AREA_W-1:0] area_i,
  input wire logic stylus_i,
  input wire logic grip_en_i,
  input wire logic [COORD_W-1:0] border_i,
  input wire logic large_en_i,
  input wire logic [AREA_W-1:0] large_area_i,
  input wire logic [SIG_W-1:0] finger_thr_i,
  input wire logic [SIG_W-1:0] stylus_thr_i,
  input wire logic [AREA_W-1:0] stylus_area_i,
  input wire logic [SIG_W-1:0] glove_thr_i,
  output logic valid_o,
  output logic glove_o,
  output logic stylus_o,
  output logic near_stylus_o
);
  logic in_border;
  logic finger_ok;
  logic stylus_ok;
  logic glove_ok;
  // Grip border: touches within border_i of any edge
  assign in_border = (x_i < border_i) || (y_i < border_i) ||
                     (x_i > x_max_i - border_i) || (y_i > y_max_i - border_i);
  assign stylus_ok = stylus_i && (signal_i >= stylus_thr_i) && (area_i <= stylus_area_i);
  assign finger_ok = !stylus_i && (signal_i >= finger_thr_i);
  assign glove_ok = !stylus_i && !finger_ok && (signal_i >= glove_thr_i);
  assign stylus_o = touch_i && stylus_ok;
  assign glove_o = touch_i && glove_ok;
  // Any non-stylus contact is taken as the holding hand when a stylus is active
  assign near_stylus_o = touch_i && !stylus_i;
  assign valid_o = touch_i && (stylus_ok || finger_ok || glove_ok)
                   && !(grip_en_i && in_border)
                   && !(large_en_i && area_i > large_area_i);
endmodule // trs_touch_filter
`default_nettype wire
